// ---- core/paged_register_file.sv ----
`timescale 1ns/1ns
// Behaviour
// RULE_01: 240 stored bytes in groups 0 to E.
// RULE_02: Groups 0 to D are general purpose.
// RULE_03: Group E reachable by every mode.
// RULE_04: Addresses F0 to FF window onto pages.
// RULE_05: Page register EA selects page, holds.
// RULE_06: Low address nibble indexes selected page.
// RULE_07: One 8-bit direct address per register.
// RULE_08: Group D only reachable by working mode.
// RULE_09: Working index 0-15 translated via pointers.
// RULE_10: One 16-block or two 8-blocks scheme.
// RULE_11: Pages exist only for present peripherals.
// RULE_12: Separate 8-bit address and data buses.
// RULE_13: Software sets page before paged access.
// RULE_14: Unimplemented page: writes ignored, reads zero.
module paged_register_file
  import regfile_pkg::*;
#(
  parameter logic [NUM_PAGES-1:0] PAGE_PRESENT = 64'h0000_0000_0000_0001
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire reg_req_t req,
  output logic [7:0] rdata,
  output logic [7:0] page_select_reg,
  output logic [7:0] pg_addr,
  output logic [7:0] pg_wdata,
  output logic pg_wr,
  output logic pg_rd,
  output logic [5:0] pg_page,
  input wire logic [7:0] pg_rdata
);

  ////////////////////////////////////////////////////////////////////////
  logic [7:0] mem_q [NUM_STORED];
  logic [7:0] page_q;
  logic [7:0] eff_addr;
  logic [7:0] ptr0;
  logic [7:0] ptr1;
  logic blocked;
  logic paged;
  logic page_ok;

  assign ptr0 = mem_q[PTR0_ADDR];
  assign ptr1 = mem_q[PTR1_ADDR];

  // Working index: split scheme uses ptr0 for r0-r7 and ptr1 for r8-r15.
  always_comb begin
    eff_addr = req.addr; // [RULE_07]
    if (req.indirect) begin // [RULE_09]
      if (ptr0[PTR_SPLIT_BIT]) begin // [RULE_10]
        eff_addr = req.addr[3] ? {ptr1[7:3], req.addr[2:0]} : {ptr0[7:3], req.addr[2:0]};
      end else begin
        eff_addr = {ptr0[7:4], req.addr[3:0]}; // [RULE_10]
      end
    end
  end

  assign blocked = !req.indirect && (eff_addr[7:4] == GROUP_D); // [RULE_08]
  assign paged = (eff_addr[7:4] == GROUP_F); // [RULE_04]
  assign page_ok = (page_q < NUM_PAGES) && PAGE_PRESENT[page_q[5:0]]; // [RULE_11]

  ////////////////////////////////////////////////////////////////////////
  // Stored registers, groups 0 to E, including the page select register.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_STORED; i++) begin
        mem_q[i] <= RESET_BYTE;
      end
    end else if (req.wr && !blocked && !paged) begin // [RULE_01] [RULE_02] [RULE_03]
      mem_q[eff_addr] <= req.wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      page_q <= PAGE_NONE;
    end else if (req.wr && eff_addr == PAGE_SELECT_ADDR) begin // [RULE_05]
      page_q <= req.wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Paged window strobes, registered; the peripheral answers on pg_rdata.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pg_wr <= 1'b0;
      pg_rd <= 1'b0;
      pg_addr <= RESET_BYTE;
      pg_wdata <= RESET_BYTE;
      pg_page <= 6'h00;
    end else begin
      pg_wr <= req.wr && paged && page_ok; // [RULE_14]
      pg_rd <= req.rd && paged && page_ok;
      pg_addr <= {4'h0, eff_addr[3:0]}; // [RULE_06]
      pg_wdata <= req.wdata;
      pg_page <= page_q[5:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      page_select_reg <= PAGE_NONE;
    end else if (req.wr && eff_addr == PAGE_SELECT_ADDR) begin
      page_select_reg <= req.wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data one cycle after the request; paged reads come from the peripheral.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata <= RESET_BYTE;
    end else if (req.rd) begin // [RULE_12]
      if (blocked || (paged && !page_ok)) begin
        rdata <= RESET_BYTE; // [RULE_14]
      end else if (paged) begin
        rdata <= pg_rdata; // [RULE_04]
      end else begin
        rdata <= mem_q[eff_addr];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Page select register.
  page_hold_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_05]
    !(req.wr && eff_addr == PAGE_SELECT_ADDR) |=> page_select_reg == $past(page_select_reg))
    else $error("page select changed without a write");
  page_load_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_05]
    req.wr && eff_addr == PAGE_SELECT_ADDR |=> page_select_reg == $past(req.wdata))
    else $error("page select not loaded");
  page_keep_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_05]
    !(req.wr && eff_addr == PAGE_SELECT_ADDR) |=> $stable(page_q))
    else $error("selected page changed without a write");
  store_page_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_05]
    req.wr && eff_addr == PAGE_SELECT_ADDR |=> mem_q[PAGE_SELECT_ADDR] == page_q)
    else $error("stored page select differs from selected page");
  reset_clear_a: assert property (@(posedge clk) // [RULE_05]
    !rst_n |=> page_select_reg == PAGE_NONE && !pg_wr && !pg_rd && rdata == RESET_BYTE)
    else $error("outputs not cleared by reset");

  // Direct addressing of the stored groups.
  group_d_block_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_08]
    req.rd && !req.indirect && req.addr[7:4] == GROUP_D |=> rdata == RESET_BYTE)
    else $error("group D reached directly");
  blocked_write_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_08]
    req.wr && !req.indirect && req.addr[7:4] == GROUP_D |=> mem_q[$past(req.addr)] == $past(mem_q[req.addr]))
    else $error("group D written directly");
  direct_store_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_02]
    req.wr && !req.indirect && req.addr <= GP_LAST && req.addr[7:4] != GROUP_D
    |=> mem_q[$past(req.addr)] == $past(req.wdata))
    else $error("direct write not stored");
  gp_read_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_02]
    req.rd && !req.indirect && req.addr <= GP_LAST && req.addr[7:4] != GROUP_D
    |=> rdata == $past(mem_q[req.addr]))
    else $error("general purpose read wrong");
  system_store_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_03]
    req.wr && !req.indirect && req.addr[7:4] == GROUP_E |=> mem_q[$past(req.addr)] == $past(req.wdata))
    else $error("system register write not stored");
  system_read_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_03]
    req.rd && eff_addr[7:4] == GROUP_E |=> rdata == $past(mem_q[eff_addr]))
    else $error("system register read wrong");

  // Working-register addressing through the pointers.
  work_map_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_10]
    req.wr && req.indirect && !ptr0[PTR_SPLIT_BIT] && ptr0[7:4] != GROUP_F
    |=> mem_q[{$past(ptr0[7:4]), $past(req.addr[3:0])}] == $past(req.wdata))
    else $error("working register mapping wrong");
  split_low_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_10]
    req.wr && req.indirect && ptr0[PTR_SPLIT_BIT] && !req.addr[3] && ptr0[7:4] != GROUP_F
    |=> mem_q[{$past(ptr0[7:3]), $past(req.addr[2:0])}] == $past(req.wdata))
    else $error("low working block write lost");
  split_high_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_10]
    req.wr && req.indirect && ptr0[PTR_SPLIT_BIT] && req.addr[3] && ptr1[7:4] != GROUP_F
    |=> mem_q[{$past(ptr1[7:3]), $past(req.addr[2:0])}] == $past(req.wdata))
    else $error("high working block write lost");
  ptr_read_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_09]
    req.rd && req.indirect && !ptr0[PTR_SPLIT_BIT] && ptr0[7:4] != GROUP_F
    |=> rdata == $past(mem_q[{ptr0[7:4], req.addr[3:0]}]))
    else $error("working register read wrong");
  indirect_d_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_08]
    req.rd && req.indirect && eff_addr[7:4] == GROUP_D |=> rdata == $past(mem_q[eff_addr]))
    else $error("group D not reached by working register");

  // Paged window.
  bad_page_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_14]
    req.wr && paged && !page_ok |=> !pg_wr)
    else $error("write to missing page passed");
  bad_page_rd_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_14]
    req.rd && paged && !page_ok |=> rdata == RESET_BYTE)
    else $error("missing page read not zero");
  page_index_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_06]
    req.wr && paged && page_ok |=> pg_wr && pg_addr[3:0] == $past(eff_addr[3:0]))
    else $error("page index wrong");
  page_read_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_04]
    req.rd && paged && page_ok |=> pg_rd && pg_page == $past(page_q[5:0])
    && pg_addr == {4'h0, $past(eff_addr[3:0])} && rdata == $past(pg_rdata))
    else $error("paged read not passed to the window");
  page_write_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_12]
    req.wr && paged && page_ok |=> pg_wdata == $past(req.wdata) && pg_page == $past(page_q[5:0]))
    else $error("paged write data wrong");
  direct_page_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_08]
    req.wr && !req.indirect && req.addr[7:4] == GROUP_F && page_ok |=> pg_wr)
    else $error("paged group not reached directly");
  ind_page_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_09]
    req.rd && req.indirect && paged && page_ok |=> pg_rd)
    else $error("paged group not reached by working register");
  wr_quiet_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_14]
    !(req.wr && paged && page_ok) |=> !pg_wr)
    else $error("paged write strobe without a request");
  rd_quiet_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_11]
    !(req.rd && paged && page_ok) |=> !pg_rd)
    else $error("paged read strobe without a request");
  page_range_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_11]
    pg_wr || pg_rd |-> PAGE_PRESENT[pg_page])
    else $error("strobe toward a missing page");
  pg_upper_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_06]
    pg_wr || pg_rd |-> pg_addr[7:4] == 4'h0)
    else $error("page index out of range");
  rdata_hold_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_12]
    !req.rd |=> $stable(rdata))
    else $error("read data changed without a read");

endmodule // paged_register_file

// ---- core/regfile_pkg.sv ----
package regfile_pkg;

  // Address map of the register file.
  localparam logic [7:0] GP_LAST = 8'hDF;
  localparam logic [3:0] GROUP_D = 4'hD;
  localparam logic [3:0] GROUP_E = 4'hE;
  localparam logic [3:0] GROUP_F = 4'hF;
  localparam logic [7:0] PAGE_SELECT_ADDR = 8'hEA;
  localparam logic [7:0] PTR0_ADDR = 8'hE8;
  localparam logic [7:0] PTR1_ADDR = 8'hE9;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam int NUM_STORED = 240;
  localparam int NUM_PAGES = 64;
  localparam int PAGE_REGS = 16;
  // Pointer register layout: bits 7:3 hold an 8-register block base (bits 7:4 a 16-register base), bit 2 of ptr0 selects the scheme.
  localparam int PTR_SPLIT_BIT = 2;
  localparam logic [7:0] PAGE_NONE = 8'h00;

  typedef struct packed {
    logic rd;
    logic wr;
    logic indirect;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

endpackage

// ---- testbench/periph_model.sv ----
`timescale 1ns/1ns
module periph_model (
  input wire logic [7:0] page,
  input wire logic [3:0] idx,
  output logic [7:0] rdata
);
  // Each present page answers at once with a fixed mix of its number and index.
  assign rdata = {page[3:0], idx} ^ 8'h5A;
endmodule // periph_model

// ---- testbench/paged_register_file_tb.sv ----
`timescale 1ns/1ns
module paged_register_file_tb;
  import regfile_pkg::*;
  logic clk = 0;
  logic rst_n = 0;
  reg_req_t req = '0;
  logic [7:0] rdata, psel, pg_addr, pg_wdata, pg_rdata;
  logic pg_wr, pg_rd;
  logic [3:0] pidx = '0;
  logic [5:0] pg_page;
  int err_total = 0;
  int tests_run = 0;
  int m [256];
  always #10 clk = ~clk;
  paged_register_file #(.PAGE_PRESENT(64'h21)) dut (.clk(clk), .rst_n(rst_n), .req(req), .rdata(rdata),
    .page_select_reg(psel), .pg_addr(pg_addr), .pg_wdata(pg_wdata), .pg_wr(pg_wr), .pg_rd(pg_rd),
    .pg_page(pg_page), .pg_rdata(pg_rdata));
  periph_model pm (.page(psel), .idx(pidx), .rdata(pg_rdata));
  task automatic chk(string n, logic [7:0] e, logic [7:0] s);
    tests_run++;
    if (s !== e) begin
      $display("unexpected %s expected %h seen %h", n, e, s);
      err_total++;
    end
  endtask
  function automatic int eff(int a, bit ind);
    if (!ind) return a;
    if (!m[232][2]) return (m[232] & 'hF0) | (a & 15);
    return (m[a[3] ? 233 : 232] & 'hF8) | (a & 7);
  endfunction
  task automatic acc(bit w, int a, bit ind, int d);
    int e, p;
    bit hit;
    e = eff(a, ind);
    p = m[234];
    hit = e >= 240 && p < 64 && ((33 >> p) & 1);
    @(negedge clk);
    req.rd = !w;
    req.wr = w;
    req.indirect = ind;
    req.addr = a[7:0];
    req.wdata = d[7:0];
    pidx = e[3:0];
    @(negedge clk);
    req = '0;
    chk("pg_wr", hit && w, {7'b0, pg_wr});
    chk("pg_rd", hit && !w, {7'b0, pg_rd});
    if (hit) begin
      chk("pg_page", {2'b0, p[5:0]}, {2'b0, pg_page});
      chk("pg_addr", e & 15, pg_addr);
      if (w) chk("pg_wdata", d, pg_wdata);
      else chk("rdata", ((p & 15) << 4 | (e & 15)) ^ 'h5A, rdata);
    end else if (e >= 240 || (!ind && e >= 208 && e < 224)) begin
      if (!w) chk("rdata", 0, rdata);
    end else if (w) m[e] = d;
    else chk("rdata", m[e], rdata);
    chk("page_select_reg", m[234], psel);
  endtask
  task automatic end_sim();
    if (err_total == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    void'($urandom(32'hD6E7));
    repeat (3) @(negedge clk);
    rst_n = 1;
    acc(0, 234, 0, 0);
    acc(1, 234, 0, 5);
    acc(0, 242, 0, 0);
    acc(1, 243, 0, 'h77);
    acc(1, 234, 0, 7);
    acc(0, 242, 0, 0);
    acc(1, 243, 0, 1);
    acc(1, 208, 0, 9);
    acc(1, 232, 0, 'hD0);
    acc(1, 3, 1, 'h44);
    acc(0, 211, 0, 0);
    acc(1, 232, 0, 'h34);
    acc(1, 233, 0, 'h58);
    acc(1, 9, 1, 8);
    acc(0, 89, 0, 0);
    rst_n = 0;
    repeat (2) @(negedge clk);
    rst_n = 1;
    m = '{default: 0};
    chk("page_select_reg", 0, psel);
    acc(0, 89, 0, 0);
    acc(0, 234, 0, 0);
    for (int i = 0; i < 300; i++) acc($urandom % 2, $urandom % 256, $urandom % 2, $urandom % 256);
    end_sim();
  end
endmodule // paged_register_file_tb
